// ===== src/usw_cfg.svh
`ifndef USW_CFG_SVH
`define USW_CFG_SVH
// field positions
`define USW_IER_SLEEP_BIT 4
`define USW_ISR_NOIRQ_BIT 0
`define USW_ISR_WAKE_CODE 4'h1
// oscillator restart wait
`define USW_OSC_START_NS 2000
`define USW_CLK_NS 40
`define USW_OSC_START_CYC ((`USW_OSC_START_NS + `USW_CLK_NS - 1) / `USW_CLK_NS)
`define USW_CNT_W 8
`endif

// ===== src/usw_pkg.sv
`default_nettype none
package usw_pkg;
    typedef enum logic [1:0] {
        USW_ACTIVE = 2'b00,
        USW_ASLEEP = 2'b01,
        USW_WAKING = 2'b10
    } usw_mode_type;

    typedef struct packed {
        logic [7:0] divisor_low_byte;
        logic [7:0] divisor_high_byte;
        logic [7:0] irq_enable_reg;
        logic       irq_none;
        logic [3:0] modem_change;
        logic       rx_busy;
    } usw_cond_type;

    typedef struct packed {
        usw_mode_type mode;
        logic [7:0] cnt;
        logic osc_stop;
        logic wake_irq;
        logic asleep;
    } usw_state_type;

    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
    } usw_sync_type;
endpackage
`default_nettype wire

// ===== src/usw_rx_sync.sv
`include "usw_cfg.svh"
`default_nettype none
// two-stage synchroniser and falling-edge detect for the serial input
module usw_rx_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // serial line
    input wire logic rx_pin,
    output logic rx_level,
    output logic rx_start_edge
);
    import usw_pkg::*;
    usw_sync_type s_reg;
    usw_sync_type s_next;

    always_comb begin
        s_next = s_reg;
        s_next.rx_meta = rx_pin;
        s_next.rx_sync = s_reg.rx_meta;
        s_next.rx_prev = s_reg.rx_sync;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '{rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rx_level = s_reg.rx_sync;
    assign rx_start_edge = s_reg.rx_prev & ~s_reg.rx_sync;
endmodule
`default_nettype wire

// ===== src/usw_sleep_ctrl.sv
`include "usw_cfg.svh"
`default_nettype none
module usw_sleep_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // uart state, same clock
    input wire usw_pkg::usw_cond_type cond,
    input wire logic tx_write,
    input wire logic status_read,
    // serial input pin
    input wire logic rx_pin,
    // results
    output logic osc_stop,
    output logic wake_irq,
    output logic asleep
);
    import usw_pkg::*;

    // ----------------------------------------
    // wake sources
    // ----------------------------------------
    logic rx_level;
    logic rx_start_edge;
    logic sleep_en;
    logic may_sleep;
    logic wake_evt;
    usw_state_type st_reg;
    usw_state_type st_next;

    usw_rx_sync u_rx (
        .mclk(mclk),
        .arst_n(arst_n),
        .rx_pin(rx_pin),
        .rx_level(rx_level),
        .rx_start_edge(rx_start_edge)
    );

    assign sleep_en = cond.irq_enable_reg[`USW_IER_SLEEP_BIT];
    assign may_sleep = sleep_en
        && ({cond.divisor_high_byte, cond.divisor_low_byte} != 16'h0000)
        && cond.irq_none && !st_reg.wake_irq
        && (cond.modem_change == 4'h0)
        && rx_level && !cond.rx_busy;
    // modem-change and write are level/pulse inputs on the free clock
    assign wake_evt = rx_start_edge
        || tx_write
        || (cond.modem_change != 4'h0);

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        unique case (st_reg.mode)
            USW_ACTIVE: begin
                if (may_sleep && !wake_evt) begin
                    st_next.mode = USW_ASLEEP;
                end
            end
            USW_ASLEEP: begin
                if (wake_evt || !sleep_en) begin
                    st_next.mode = USW_WAKING;
                    st_next.cnt = 8'h00;
                end
            end
            USW_WAKING: begin
                // oscillator restart; receive data may be lost here
                if (st_reg.cnt == 8'(`USW_OSC_START_CYC - 1)) begin
                    st_next.mode = USW_ACTIVE;
                    st_next.wake_irq = sleep_en;
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            default: begin
                st_next.mode = USW_ACTIVE;
            end
        endcase
        if (status_read && st_reg.wake_irq) begin
            st_next.wake_irq = 1'b0;
        end
        st_next.osc_stop = (st_next.mode == USW_ASLEEP);
        st_next.asleep = (st_next.mode != USW_ACTIVE);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{mode: USW_ACTIVE, cnt: 8'h00, osc_stop: 1'b0,
                        wake_irq: 1'b0, asleep: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign osc_stop = st_reg.osc_stop;
    assign wake_irq = st_reg.wake_irq;
    assign asleep = st_reg.asleep;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // longest wait from a wake edge to the wake interrupt, restart included
    localparam int WAKE_IRQ_MAX = `USW_OSC_START_CYC + 1;

    property p_no_sleep_zero_div;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE &&
         {cond.divisor_high_byte, cond.divisor_low_byte} == 16'h0000)
        |=> !osc_stop;
    endproperty
    a_no_sleep_zero_div: assert property (p_no_sleep_zero_div)
        else $error("sleep entered with zero divisor");

    property p_no_sleep_disabled;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE && !sleep_en) |=> !osc_stop;
    endproperty
    a_no_sleep_disabled: assert property (p_no_sleep_disabled)
        else $error("sleep entered while disabled");

    property p_no_sleep_pending;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE && (!cond.irq_none || wake_irq))
        |=> !osc_stop;
    endproperty
    a_no_sleep_pending: assert property (p_no_sleep_pending)
        else $error("sleep entered with interrupt pending");

    property p_no_sleep_modem;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE && cond.modem_change != 4'h0)
        |=> !osc_stop;
    endproperty
    a_no_sleep_modem: assert property (p_no_sleep_modem)
        else $error("sleep entered with modem change");

    property p_no_sleep_rx;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE && cond.rx_busy) |=> !osc_stop;
    endproperty
    a_no_sleep_rx: assert property (p_no_sleep_rx)
        else $error("sleep entered during reception");

    property p_wake_tx;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && tx_write) |=> !osc_stop;
    endproperty
    a_wake_tx: assert property (p_wake_tx)
        else $error("transmit write did not wake");

    property p_wake_modem;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && cond.modem_change != 4'h0) |=> !osc_stop;
    endproperty
    a_wake_modem: assert property (p_wake_modem)
        else $error("modem change did not wake");

    property p_wake_irq;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && tx_write && sleep_en) |-> ##[1:WAKE_IRQ_MAX] wake_irq;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("no wake interrupt after restart");

    property p_irq_clear;
        @(posedge mclk) disable iff (!arst_n)
        (wake_irq && status_read) |=> !wake_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("wake interrupt not cleared by read");

    property p_resleep;
        @(posedge mclk) disable iff (!arst_n)
        (st_reg.mode == USW_ACTIVE && may_sleep && !wake_evt) |=> osc_stop;
    endproperty
    a_resleep: assert property (p_resleep)
        else $error("did not return to sleep");

    property p_wake_rx;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && rx_start_edge) |=> !osc_stop;
    endproperty
    a_wake_rx: assert property (p_wake_rx)
        else $error("receive start edge did not wake");

    property p_sleep_holds;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && sleep_en && !wake_evt) |=> osc_stop;
    endproperty
    a_sleep_holds: assert property (p_sleep_holds)
        else $error("left sleep with no wake event while enabled");

    property p_disable_wake;
        @(posedge mclk) disable iff (!arst_n)
        (osc_stop && !sleep_en) |=> !osc_stop ##[1:WAKE_IRQ_MAX] !asleep;
    endproperty
    a_disable_wake: assert property (p_disable_wake)
        else $error("clearing sleep enable did not restart");

    c_sleep: cover property (@(posedge mclk) $rose(osc_stop));
    c_wake: cover property (@(posedge mclk) $fell(osc_stop));
    c_irq: cover property (@(posedge mclk) $rose(wake_irq));
    c_rx_wake: cover property (@(posedge mclk) osc_stop && rx_start_edge);
    c_modem_wake: cover property (@(posedge mclk)
        osc_stop && cond.modem_change != 4'h0);
endmodule
`default_nettype wire

// ===== test/test_uart_sleep_wake_control.sv
`default_nettype none
module test_uart_sleep_wake_control;
    timeunit 1ns;
    timeprecision 1ps;
    import usw_pkg::*;
    typedef struct packed {
        usw_cond_type c;
        logic exp;
    } usw_row_type;
    logic mclk = 0, arst_n = 0, tx_write = 0, rx_pin = 1;
    logic status_read, msr_read, osc_stop, wake_irq, asleep;
    logic [7:0] lag = 8'h02;
    int n_mismatch = 0, checked = 0;
    usw_cond_type cond, good;
    usw_row_type rows [8];
    always #20 mclk = ~mclk;
    usw_sleep_ctrl DUT (.mclk(mclk), .arst_n(arst_n), .cond(cond),
        .tx_write(tx_write), .status_read(status_read), .rx_pin(rx_pin),
        .osc_stop(osc_stop), .wake_irq(wake_irq), .asleep(asleep));
    usw_host_model host (.mclk(mclk), .arst_n(arst_n), .wake_irq(wake_irq),
        .lag(lag), .status_read(status_read), .msr_read(msr_read));
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task wait_for(input string name, input logic v, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(negedge mclk);
            if ((name == "osc_stop" ? osc_stop :
                 name == "wake_irq" ? wake_irq : msr_read) === v) return;
        end
        chk(name, v, ~v);
        stop_test;
    endtask
    task do_reset;
        arst_n = 0;
        repeat (5) @(negedge mclk);
        arst_n = 1;
    endtask
    initial begin
        good = '{8'h01, 8'h00, 8'h10, 1'b1, 4'h0, 1'b0};
        cond = good;
        rows[0] = '{good, 1'b1};
        rows[1] = '{'{8'h00, 8'h00, 8'h10, 1'b1, 4'h0, 1'b0}, 1'b0};
        rows[2] = '{'{8'h00, 8'h01, 8'h10, 1'b1, 4'h0, 1'b0}, 1'b1};
        rows[3] = '{'{8'h01, 8'h00, 8'hef, 1'b1, 4'h0, 1'b0}, 1'b0};
        rows[4] = '{'{8'h01, 8'h00, 8'h10, 1'b0, 4'h0, 1'b0}, 1'b0};
        rows[5] = '{'{8'h01, 8'h00, 8'h10, 1'b1, 4'h1, 1'b0}, 1'b0};
        rows[6] = '{'{8'h01, 8'h00, 8'h10, 1'b1, 4'h8, 1'b0}, 1'b0};
        rows[7] = '{'{8'h01, 8'h00, 8'h10, 1'b1, 4'h0, 1'b1}, 1'b0};
        for (int i = 0; i < 8; i++) begin
            cond = rows[i].c;
            do_reset;
            repeat (3) @(negedge mclk);
            chk("osc_stop", rows[i].exp, osc_stop);
            chk("asleep", rows[i].exp, asleep);
            $display("row %0d done", i);
        end
        // ----------------------------------------
        // wake sources, service and re-entry
        // ----------------------------------------
        do_reset;
        cond = good;
        wait_for("osc_stop", 1'b1, 4);
        tx_write = 1'b1;
        @(negedge mclk);
        tx_write = 1'b0;
        wait_for("osc_stop", 1'b0, 2);
        chk("asleep", 1'b1, asleep);
        wait_for("wake_irq", 1'b1, 60);
        chk("asleep", 1'b0, asleep);
        wait_for("wake_irq", 1'b0, 8);
        wait_for("osc_stop", 1'b1, 4);
        $display("transmit wake done");
        lag = 8'h10;
        rx_pin = 1'b0;
        wait_for("osc_stop", 1'b0, 5);
        rx_pin = 1'b1;
        wait_for("wake_irq", 1'b1, 60);
        repeat (8) @(negedge mclk);
        chk("wake_irq", 1'b1, wake_irq);
        chk("osc_stop", 1'b0, osc_stop);
        wait_for("osc_stop", 1'b1, 30);
        $display("receive wake done");
        lag = 8'h02;
        cond.modem_change = 4'h4;
        wait_for("osc_stop", 1'b0, 4);
        wait_for("wake_irq", 1'b1, 60);
        // change bits stay set until the host reads modem status
        wait_for("msr_read", 1'b1, 8);
        @(negedge mclk);
        chk("osc_stop", 1'b0, osc_stop);
        cond.modem_change = 4'h0;
        wait_for("osc_stop", 1'b1, 10);
        $display("modem wake done");
        cond.irq_enable_reg = 8'h00;
        wait_for("osc_stop", 1'b0, 4);
        repeat (60) @(negedge mclk);
        chk("wake_irq", 1'b0, wake_irq);
        chk("osc_stop", 1'b0, osc_stop);
        chk("asleep", 1'b0, asleep);
        $display("disable done");
        // reset in mid-restart drops every output and the interrupt
        cond = good;
        wait_for("osc_stop", 1'b1, 4);
        tx_write = 1'b1;
        @(negedge mclk);
        tx_write = 1'b0;
        arst_n = 1'b0;
        @(negedge mclk);
        chk("asleep", 1'b0, asleep);
        chk("osc_stop", 1'b0, osc_stop);
        arst_n = 1'b1;
        wait_for("osc_stop", 1'b1, 4);
        chk("wake_irq", 1'b0, wake_irq);
        $display("reset done");
        stop_test;
    end
endmodule
`default_nettype wire

// ===== test/usw_host_model.sv
`default_nettype none
// host side: services the wake interrupt after lag cycles
module usw_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // device side
    input wire logic wake_irq,
    input wire logic [7:0] lag,
    output logic status_read,
    output logic msr_read
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    always @(negedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_read <= 1'b0;
            msr_read <= 1'b0;
            wait_cnt <= 0;
        end else begin
            // one read of each register, lag cycles after the interrupt
            msr_read <= wake_irq && (wait_cnt == lag);
            status_read <= wake_irq && (wait_cnt == lag);
            if (!wake_irq) begin
                wait_cnt <= 0;
            end else if (wait_cnt <= lag) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire
